/* File: logic/cch_pkg.sv */
// shared constants of the calibration command handler
// assumes one host acting as serial master on a byte-framed link
package cch_pkg;

  // ==========================================================
  // frame type codes of the handled commands and of the record reply
  localparam logic [7:0] CCH_PERSIST_SETTINGS_CMD = 8'h09;
  localparam logic [7:0] CCH_BEGIN_CALIBRATION_CMD = 8'h0A;
  localparam logic [7:0] CCH_END_CALIBRATION_CMD = 8'h0B;
  localparam logic [7:0] CCH_READ_CALIBRATION_CMD = 8'h0C;
  localparam logic [7:0] CCH_CALIBRATION_RECORD_REPLY = 8'h0D;
  localparam logic [7:0] CCH_LOAD_CALIBRATION_CMD = 8'h0E;

  // ==========================================================
  // calibration record layout
  localparam int CCH_REC_WORDS = 6; // x off, y off, x gain, y gain, phase, magnitude
  localparam logic [7:0] CCH_REC_BYTES = 8'h18; // length byte value, 24
  localparam logic [4:0] CCH_REC_LAST = 5'h18; // count of the final payload byte
  localparam logic [4:0] CCH_REPLY_END = 5'h19; // count after the final reply byte

  // ==========================================================
  // reset values
  localparam logic [7:0] CCH_CAL_RATE_RST = 8'h08; // calibration sampling rate in Hz
  localparam logic [7:0] CCH_IDLE_BYTE = 8'h00; // shifted out while receiving
  localparam logic [2:0] CCH_BIT_RST = 3'h0;

  // calibration record: word 0 is x offset, word 5 the magnitude
  typedef logic [CCH_REC_WORDS-1:0][31:0] cch_rec_t;

  // command parser states
  typedef enum logic [1:0] {
    CCH_IDLE,
    CCH_LOAD,
    CCH_REPLY
  } cch_state_t;

endpackage

/* File: logic/cch_spi_shifter.sv */
// serial slave shifter running on the host's serial clock
// assumes mode 0 framing and a clear that is high outside frames
`timescale 1ns/1ps

module cch_spi_shifter
  import cch_pkg::*;
(
  input wire logic spi_sclk, // serial clock from the host
  input wire logic frame_clr, // async: select high or resync clear
  input wire logic hand_clr, // async: held while the system side resets
  input wire logic mosi, // data from the host
  input wire logic [7:0] tx_byte, // next byte to send, quasi-static
  output logic miso_o, // data to the host
  output logic [7:0] rx_byte, // last whole byte received, held
  output logic rx_tog // flips once per received byte
);

  // ==========================================================
  // frame state, cleared whenever no frame is open
  typedef struct packed {
    logic [2:0] bit_cnt; // bits taken in this byte
    logic [6:0] sh; // partial byte, msb first
  } cch_frm_t;

  // handoff state, kept across frames so the toggle never jumps
  typedef struct packed {
    logic [7:0] byte_v; // byte offered to the system side
    logic tog; // event toggle
  } cch_hnd_t;

  cch_frm_t frm_q, frm_d;
  cch_hnd_t hnd_q, hnd_d;
  logic [7:0] tx_sh_q; // outgoing byte, moved on falling edges

  // next value on each rising edge: mosi sampled here
  always_comb begin
    frm_d = frm_q;
    hnd_d = hnd_q;
    frm_d.bit_cnt = frm_q.bit_cnt + 3'h1;
    frm_d.sh = {frm_q.sh[5:0], mosi};
    if (frm_q.bit_cnt == 3'h7) begin
      // eighth bit: hand the byte over and flip the event
      hnd_d.byte_v = {frm_q.sh, mosi};
      hnd_d.tog = ~hnd_q.tog;
    end
  end

  // shifter and bit count; an open select keeps them at zero
  always_ff @(posedge spi_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      frm_q <= '0;
    end else begin
      frm_q <= frm_d;
    end
  end

  // handoff register, only cleared by the system reset
  always_ff @(posedge spi_sclk or posedge hand_clr) begin
    if (hand_clr) begin
      hnd_q <= '0;
    end else begin
      hnd_q <= hnd_d;
    end
  end

  // next bit after each falling edge; a new byte loads after bit eight.
  // tx_byte must have settled a byte earlier, so replies lag one byte
  always_ff @(negedge spi_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      tx_sh_q <= CCH_IDLE_BYTE;
    end else if (frm_q.bit_cnt == CCH_BIT_RST) begin
      tx_sh_q <= tx_byte;
    end else begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  assign miso_o = tx_sh_q[7];
  assign rx_byte = hnd_q.byte_v;
  assign rx_tog = hnd_q.tog;

endmodule

/* File: logic/cch_handler.sv */
// calibration and save command handler with its serial slave port
// assumes a host master on the serial pins and a calibration engine,
// settings store and non-volatile writer on the system clock
//
// Contract
// - save command writes settings to non-volatile storage
// - save also keeps outputs list and calibration
// - begin command starts calibration at chosen rate
// - end command applies calibration, unsaved until save
// - read command answers with calibration record reply
// - reply: length 24, four ints, two floats
// - load command replaces the calibration record
// - five link signals, select low active, resync optional
// - host drives serial clock; device is slave
// - sample on rising edge, shift out on falling
// - half duplex; zeros while receiving, mosi ignored replying
// - resync rising edge clears shifter and buffers
// - multi-byte values ordered by the byte-order setting
`timescale 1ns/1ps

module cch_handler
  import cch_pkg::*;
#(
  parameter int REC_WORDS = CCH_REC_WORDS // words in the calibration record
)
(
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic spi_sclk, // serial clock from the host
  input wire logic mosi, // serial data in
  output logic miso_o, // serial data out
  output logic miso_oe, // high while selected
  input wire logic slave_select_n, // frame select, active low
  input wire logic resync_pin, // asynchronous resynchronise, rising edge
  input wire logic msb_first_order, // byte order setting, same clock
  input wire logic [7:0] calibration_sample_rate, // chosen rate, same clock
  input wire cch_rec_t cal_result, // record from the calibration engine
  output logic cal_running, // calibration run in progress
  output logic [7:0] cal_rate_sel, // rate latched at the run start
  output cch_rec_t cal_record, // record in use for heading
  output logic cal_unsaved, // record differs from stored copy
  output logic persist_req // one-cycle request to store everything
);

  // ==========================================================
  // elaboration check: the byte counters serve a 24 byte record only
  if (REC_WORDS != CCH_REC_WORDS) begin : g_bad_words
    $error("cch_handler: record must be six words");
  end

  // ==========================================================
  // all system-side state
  typedef struct packed {
    logic rx_s1; // byte toggle, first stage
    logic rx_s2; // byte toggle, second stage
    logic rx_s3; // previous, for the event
    logic ss_s1; // select, first stage
    logic ss_s2; // select, second stage
    logic sy_s1; // resync, first stage
    logic sy_s2; // resync, second stage
    logic sy_s3; // previous, for the rising edge
    logic clr; // one-cycle clear of the link shifter
    logic link_run; // low during reset to clear the handoff
    cch_state_t st; // parser state
    logic [4:0] cnt; // payload byte count
    cch_rec_t ld_rec; // record being assembled from a load
    cch_rec_t act_rec; // record in use
    logic cal_run; // calibration active
    logic [7:0] cal_rate; // latched sampling rate
    logic dirty; // record not yet stored
    logic persist; // store request pulse
    logic [7:0] tx; // byte offered to the shifter
  } cch_sys_t;

  cch_sys_t q, d;
  logic [7:0] rx_byte; // held byte from the link side
  logic rx_tog; // per-byte toggle from the link side
  logic rx_ev; // a new byte arrived
  logic sync_rise; // resync edge seen
  logic cmd_ok; // a command byte is taken
  logic frame_clr; // async clear of the frame logic

  // ==========================================================
  // byte placement helpers, order chosen by the setting
  function automatic logic [7:0] rec_bit(input logic [4:0] k, input logic msbf);
    logic [7:0] pos;
    pos = msbf ? {3'h0, ~k[1:0], 3'h0} : {3'h0, k[1:0], 3'h0};
    rec_bit = {k[4:2], 5'h00} + pos;
  endfunction

  function automatic logic [7:0] get_byte(input cch_rec_t r, input logic [4:0] k, input logic msbf);
    logic [191:0] flat;
    flat = r;
    get_byte = flat[rec_bit(k, msbf) +: 8];
  endfunction

  function automatic cch_rec_t put_byte(input cch_rec_t r, input logic [4:0] k, input logic [7:0] b,
                                        input logic msbf);
    logic [191:0] flat;
    flat = r;
    flat[rec_bit(k, msbf) +: 8] = b;
    put_byte = flat;
  endfunction

  // ==========================================================
  // link side
  // select high or a resync clear closes the frame logic at once
  assign frame_clr = slave_select_n | q.clr;

  cch_spi_shifter u_shift (
    .spi_sclk(spi_sclk),
    .frame_clr(frame_clr),
    .hand_clr(~q.link_run),
    .mosi(mosi),
    .tx_byte(q.tx),
    .miso_o(miso_o),
    .rx_byte(rx_byte),
    .rx_tog(rx_tog)
  );

  // drive data out only while the host selects this slave
  assign miso_oe = ~slave_select_n;

  // ==========================================================
  // events seen on the system clock
  // the byte itself is not synchronised: it stands still for a whole
  // byte time after its toggle, so it is settled when the event fires
  assign rx_ev = q.rx_s2 ^ q.rx_s3;
  assign sync_rise = q.sy_s2 & ~q.sy_s3;
  assign cmd_ok = rx_ev & ~sync_rise & ~q.ss_s2 & (q.st == CCH_IDLE);

  // ==========================================================
  // command parser next state
  always_comb begin
    cch_rec_t nrec;
    nrec = put_byte(q.ld_rec, q.cnt - 5'h01, rx_byte, msb_first_order);
    d = q;
    // synchronisers; the first stages feed only the second
    d.rx_s1 = rx_tog;
    d.rx_s2 = q.rx_s1;
    d.rx_s3 = q.rx_s2;
    d.ss_s1 = slave_select_n;
    d.ss_s2 = q.ss_s1;
    d.sy_s1 = resync_pin;
    d.sy_s2 = q.sy_s1;
    d.sy_s3 = q.sy_s2;
    d.clr = 1'b0;
    d.link_run = 1'b1;
    d.persist = 1'b0;
    if (sync_rise) begin
      // drop any half-parsed frame and clear the shifter
      d.st = CCH_IDLE;
      d.cnt = 5'h00;
      d.tx = CCH_IDLE_BYTE;
      d.clr = 1'b1;
    end else if (q.ss_s2) begin
      // select released: a frame cut short is abandoned
      d.st = CCH_IDLE;
      d.cnt = 5'h00;
      d.tx = CCH_IDLE_BYTE;
    end else if (rx_ev) begin
      unique case (q.st)
        CCH_IDLE: begin
          // parameterless commands act at once
          case (rx_byte)
            CCH_PERSIST_SETTINGS_CMD: begin
              d.persist = 1'b1;
              d.dirty = 1'b0;
            end
            CCH_BEGIN_CALIBRATION_CMD: begin
              d.cal_run = 1'b1;
              d.cal_rate = calibration_sample_rate;
            end
            CCH_END_CALIBRATION_CMD: begin
              // a stray end without a run leaves the record alone
              if (q.cal_run) begin
                d.cal_run = 1'b0;
                d.act_rec = cal_result;
                d.dirty = 1'b1;
              end
            end
            CCH_READ_CALIBRATION_CMD: begin
              d.st = CCH_REPLY;
              d.cnt = 5'h00;
              d.tx = CCH_CALIBRATION_RECORD_REPLY;
            end
            CCH_LOAD_CALIBRATION_CMD: begin
              d.st = CCH_LOAD;
              d.cnt = 5'h00;
            end
            default: begin
              // other frame types belong to other blocks
            end
          endcase
        end
        CCH_LOAD: begin
          if (q.cnt == 5'h00) begin
            // a wrong length byte drops the whole frame: the count parks
            // past the record end so payload bytes are never taken as
            // commands; a command later in the same frame is lost too
            if (rx_byte != CCH_REC_BYTES) begin
              d.cnt = CCH_REPLY_END;
            end else begin
              d.cnt = 5'h01;
            end
          end else if (q.cnt == CCH_REPLY_END) begin
            // rest of a refused frame; only select or resync ends it
          end else begin
            d.ld_rec = nrec;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == CCH_REC_LAST) begin
              // commit only a whole record, never a partial one
              d.act_rec = nrec;
              d.dirty = 1'b1;
              d.st = CCH_IDLE;
              d.cnt = 5'h00;
            end
          end
        end
        CCH_REPLY: begin
          // incoming bytes only pace the reply; their value is ignored
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h00) begin
            d.tx = CCH_REC_BYTES;
          end else if (q.cnt <= CCH_REC_LAST) begin
            d.tx = get_byte(q.act_rec, q.cnt - 5'h01, msb_first_order);
          end else begin
            d.tx = CCH_IDLE_BYTE;
            d.st = CCH_IDLE;
            d.cnt = 5'h00;
          end
        end
      endcase
    end
  end

  // state register, synchronous reset
  // the rate comes back to its default value, all else to zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
      q.cal_rate <= CCH_CAL_RATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs, all from registers
  assign cal_running = q.cal_run;
  assign cal_rate_sel = q.cal_rate;
  assign cal_record = q.act_rec;
  assign cal_unsaved = q.dirty;
  assign persist_req = q.persist;

  // ==========================================================
  // checks on the system clock
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  persist_pulse_a: assert property (cmd_ok && rx_byte == CCH_PERSIST_SETTINGS_CMD
    |=> persist_req ##1 !persist_req)
    else $error("save command gave no single store pulse");
  persist_clean_a: assert property (persist_req |-> !cal_unsaved && $stable(cal_record))
    else $error("store pulse with record still marked unsaved");
  cal_start_a: assert property (cmd_ok && rx_byte == CCH_BEGIN_CALIBRATION_CMD
    |=> cal_running && cal_rate_sel == $past(calibration_sample_rate))
    else $error("begin command did not start the run at the set rate");
  cal_stop_a: assert property (cmd_ok && rx_byte == CCH_END_CALIBRATION_CMD && cal_running
    |=> !cal_running && cal_unsaved && cal_record == $past(cal_result))
    else $error("end command did not apply the new record");
  reply_head_a: assert property (cmd_ok && rx_byte == CCH_READ_CALIBRATION_CMD
    |=> q.tx == CCH_CALIBRATION_RECORD_REPLY && q.st == CCH_REPLY)
    else $error("read command did not start the reply");
  reply_len_a: assert property (q.st == CCH_REPLY && q.cnt == 5'h00 && rx_ev && !sync_rise && !q.ss_s2
    |=> q.tx == CCH_REC_BYTES)
    else $error("reply length byte is not 24");
  reply_order_a: assert property (q.st == CCH_REPLY && q.cnt == 5'h01 && rx_ev && !sync_rise && !q.ss_s2
    |=> q.tx == (msb_first_order ? q.act_rec[0][31:24] : q.act_rec[0][7:0]))
    else $error("first record byte in wrong order");
  load_commit_a: assert property (q.st == CCH_LOAD && q.cnt == CCH_REC_LAST && rx_ev && !sync_rise
    && !q.ss_s2 |=> cal_unsaved && q.st == CCH_IDLE && cal_record == q.ld_rec)
    else $error("load frame did not replace the record");
  // a refused length parks the count; the record must not move
  load_drop_a: assert property (q.st == CCH_LOAD && q.cnt == 5'h00 && rx_ev && !sync_rise
    && !q.ss_s2 && rx_byte != CCH_REC_BYTES |=> q.cnt == CCH_REPLY_END && $stable(cal_record))
    else $error("bad length load was not refused");
  resync_clear_a: assert property (sync_rise |=> q.clr && q.st == CCH_IDLE ##1 !q.clr)
    else $error("resync edge did not clear the port");
  idle_zero_a: assert property (q.st == CCH_IDLE && !$past(cmd_ok) |-> q.tx == CCH_IDLE_BYTE)
    else $error("nonzero byte offered while receiving");

  // main scenarios: calibrate and save, read back, load, refused load
  cal_cycle_c: cover property (cal_running ##[1:1000] !cal_running && cal_unsaved ##[1:1000] persist_req);
  reply_done_c: cover property (q.st == CCH_REPLY && q.cnt == CCH_REPLY_END);
  load_done_c: cover property (q.st == CCH_LOAD && q.cnt == CCH_REC_LAST && rx_ev);
  load_drop_c: cover property (q.st == CCH_LOAD && q.cnt == CCH_REPLY_END && rx_ev);

endmodule

/* File: tb/cch_host_model.sv */
// host master model for the serial command port of the handler
// assumes a mode 0 slave; link clock runs only inside frames
`timescale 1ns/1ps

module cch_host_model (
  output logic spi_sclk,
  output logic mosi,
  output logic slave_select_n,
  output logic resync_pin,
  input wire logic miso_w
);
  // ==========================================================
  // idle levels: clock low, select high
  initial begin
    spi_sclk = 1'b0;
    mosi = 1'b0;
    slave_select_n = 1'b1;
    resync_pin = 1'b0;
  end

  // ==========================================================
  // one byte each way, msb first, 6 ns link clock period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #3 spi_sclk = 1'b1;
      rx[i] = miso_w;
      #3 spi_sclk = 1'b0;
    end
    // released data line must not keep its last value
    mosi = ~mosi;
    // sys side needs about 100 ns to take each byte
    #120;
  endtask

  // select held low from command to last reply byte
  task automatic frame_open();
    slave_select_n = 1'b0;
    #20;
  endtask

  task automatic frame_close();
    #10 slave_select_n = 1'b1;
    #100;
  endtask

  // rising edge acts; held long enough for the 2ff on sys_clk
  task automatic pulse_resync();
    resync_pin = 1'b1;
    #100 resync_pin = 1'b0;
    #100;
  endtask
endmodule

/* File: tb/cch_handler_bench.sv */
// self-checking bench of the calibration command handler
// assumes a host master model on the link and a 50 MHz sys clock
`timescale 1ns/1ps

module cch_handler_bench;
  import cch_pkg::*;
  // frame type owned by another block; value arbitrary, never decoded here
  localparam logic [7:0] select_outputs_code = 8'h7e;

  // ==========================================================
  // clocks, stimulus and design
  logic sys_clk = 1'b0, rst_b = 1'b0, msb_first_order = 1'b1;
  logic spi_sclk, mosi, slave_select_n, resync_pin, miso_o, miso_oe, miso_w, miso_park = 1'b1;
  logic [7:0] calibration_sample_rate = 8'h01;
  cch_rec_t cal_result = '0;
  logic cal_running, cal_unsaved, persist_req;
  logic [7:0] cal_rate_sel;
  cch_rec_t cal_record;
  int failures = 0, total_checks = 0, persist_cnt = 0;
  logic [31:0] lfsr = 32'h0000_9e85;
  logic [31:0] m_rec [6]; // model record
  logic [7:0] txq [$], rxq [$], recq [$];
  logic [7:0] b;

  always #10 sys_clk = ~sys_clk;

  // released select: wire shows the inverse of the last bit
  always @(posedge miso_oe or negedge miso_oe) miso_park = ~miso_o;
  assign miso_w = miso_oe ? miso_o : miso_park;

  always @(posedge sys_clk) if (persist_req === 1'b1) persist_cnt++;

  cch_handler i_cch_handler (.sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_n(slave_select_n), .resync_pin(resync_pin),
    .msb_first_order(msb_first_order), .calibration_sample_rate(calibration_sample_rate),
    .cal_result(cal_result), .cal_running(cal_running), .cal_rate_sel(cal_rate_sel),
    .cal_record(cal_record), .cal_unsaved(cal_unsaved), .persist_req(persist_req));

  cch_host_model i_cch_host_model (.spi_sclk(spi_sclk), .mosi(mosi), .slave_select_n(slave_select_n),
    .resync_pin(resync_pin), .miso_w(miso_w));

  // ==========================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // whole frame from txq, replies gathered in rxq
  task automatic run_frame();
    rxq.delete();
    i_cch_host_model.frame_open();
    chk_val("miso_oe", 32'h0000_0001, miso_oe);
    foreach (txq[i]) begin
      i_cch_host_model.xfer(txq[i], b);
      rxq.push_back(b);
    end
    i_cch_host_model.frame_close();
    chk_val("miso_oe", 32'h0000_0000, miso_oe);
    repeat (6) @(negedge sys_clk);
  endtask

  // record bytes in wire order for the current byte order
  task automatic mk_rec();
    recq.delete();
    for (int w = 0; w < 6; w++)
      for (int k = 0; k < 4; k++)
        recq.push_back(msb_first_order ? m_rec[w][8*(3-k) +: 8] : m_rec[w][8*k +: 8]);
  endtask

  task automatic chk_rec();
    for (int i = 0; i < 6; i++) chk_val("cal_record", m_rec[i], cal_record[i]);
  endtask

  task automatic read_check();
    txq = {CCH_READ_CALIBRATION_CMD};
    repeat (27) txq.push_back(8'h00);
    run_frame();
    mk_rec();
    chk_byte("idle byte", CCH_IDLE_BYTE, rxq[0]);
    chk_byte("turnaround", CCH_IDLE_BYTE, rxq[1]);
    chk_byte("reply type", CCH_CALIBRATION_RECORD_REPLY, rxq[2]);
    chk_byte("length", CCH_REC_BYTES, rxq[3]);
    foreach (recq[j]) chk_byte("reply data", recq[j], rxq[4+j]);
  endtask

  // load frame; length byte given, payload from model
  task automatic load_frame(input logic [7:0] len, input int cut);
    mk_rec();
    txq = {CCH_LOAD_CALIBRATION_CMD, len};
    foreach (recq[j]) if (j < cut) txq.push_back(recq[j]);
  endtask

  task automatic new_values();
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      m_rec[i] = lfsr;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs well under 200 us
  initial begin
    #1_000_000;
    failures++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    foreach (m_rec[i]) m_rec[i] = 32'h0000_0000;
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val("rate reset", 32'h0000_0008, cal_rate_sel);
    chk_val("running reset", 32'h0000_0000, cal_running);
    chk_rec();
    // end without a run is ignored
    txq = {CCH_END_CALIBRATION_CMD};
    run_frame();
    chk_val("running", 32'h0000_0000, cal_running);
    chk_val("unsaved", 32'h0000_0000, cal_unsaved);
    // raw outputs are selected before the run; that frame is not ours
    txq = {select_outputs_code};
    run_frame();
    chk_val("running", 32'h0000_0000, cal_running);
    chk_val("persist", 32'h0000_0000, persist_cnt);
    // begin, end, save
    lfsr = next_rand(lfsr);
    calibration_sample_rate = 8'(lfsr[2:0]) + 8'h01;
    txq = {CCH_BEGIN_CALIBRATION_CMD};
    run_frame();
    chk_val("running", 32'h0000_0001, cal_running);
    chk_val("rate", {24'h00_0000, calibration_sample_rate}, cal_rate_sel);
    new_values();
    for (int i = 0; i < 6; i++) cal_result[i] = m_rec[i];
    txq = {CCH_END_CALIBRATION_CMD};
    run_frame();
    chk_val("running", 32'h0000_0000, cal_running);
    chk_val("unsaved", 32'h0000_0001, cal_unsaved);
    chk_val("persist", 32'h0000_0000, persist_cnt);
    chk_rec();
    txq = {CCH_PERSIST_SETTINGS_CMD};
    run_frame();
    chk_val("persist", 32'h0000_0001, persist_cnt);
    chk_val("unsaved", 32'h0000_0000, cal_unsaved);
    // read back in both byte orders
    for (int o = 0; o < 2; o++) begin
      msb_first_order = o[0];
      read_check();
    end
    // load with a random byte order
    lfsr = next_rand(lfsr);
    msb_first_order = lfsr[0];
    new_values();
    load_frame(CCH_REC_BYTES, 24);
    run_frame();
    foreach (rxq[j]) chk_byte("rx idle", CCH_IDLE_BYTE, rxq[j]);
    chk_rec();
    // wrong length is dropped
    for (int i = 0; i < 6; i++) m_rec[i] = ~m_rec[i];
    load_frame(8'h17, 24);
    for (int i = 0; i < 6; i++) m_rec[i] = ~m_rec[i];
    run_frame();
    chk_rec();
    chk_val("running", 32'h0000_0000, cal_running);
    chk_val("persist", 32'h0000_0001, persist_cnt);
    // resync in mid load abandons it
    new_values();
    load_frame(CCH_REC_BYTES, 10);
    for (int i = 0; i < 6; i++) m_rec[i] = cal_record[i];
    i_cch_host_model.frame_open();
    foreach (txq[i]) i_cch_host_model.xfer(txq[i], b);
    i_cch_host_model.pulse_resync();
    i_cch_host_model.frame_close();
    repeat (6) @(negedge sys_clk);
    chk_rec();
    read_check();
    chk_val("persist", 32'h0000_0001, persist_cnt);
    stop_test();
  end
endmodule
